/* File: src/fpd_pkg.sv */
// Summary of operation
// - wait 200 us, then eight wake-up cycles
// - repeat wake-up after refresh period lapse
// - write enable high throughout read cycles
// - early write: write enable before column strobe
// - read-write needs late write enable edge
// - output enable high, late write enable
// - tied output enable forbids late writes
// - output enable high before late writes
// - write data framed by leading strobe edge
// - raise both strobes to clear outputs
// - page cycles spaced by page cycle time
// - random cycles spaced by row cycle time
// - last strobe low before first rises
// - column before row starts internal refresh
// - hidden refresh after write keeps strobes
// - 512 refreshes every 8 ms
// - row half then column half addressing
`default_nettype none
package fpd_pkg;
  localparam int CLK_NS = 40;
  localparam int PAUSE_US = 200;
  localparam int PAUSE_CYC = (PAUSE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CNT = 8;
  localparam int REF_MS = 8;
  localparam int REF_ROWS = 512;
  // room for one access in flight before a due refresh starts
  localparam int REF_SLACK_CYC = 24;
  // longest spacing, rounded down, less the slack above
  localparam int REF_INT_CYC =
    (REF_MS * 1000000 / CLK_NS) / REF_ROWS - REF_SLACK_CYC;
  localparam int TRC_NS = 110;
  localparam int TRC_CYC = (TRC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRP_NS = 40;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TACC_NS = 60;
  localparam int TACC_CYC = (TACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_W = 18;
  localparam int PIN_W = 9;
  localparam int DATA_W = 16;

  typedef struct packed {
    logic              write;
    logic [1:0]        byteEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fpd_req_s;

  typedef struct packed {
    logic             rasN;
    logic             lcasN;
    logic             ucasN;
    logic             weN;
    logic             oeN;
    logic [PIN_W-1:0] addr;
  } fpd_pins_s;

  typedef enum logic [6:0] {
    ST_PAUSE = 7'b000_0001,
    ST_IDLE  = 7'b000_0010,
    ST_ROW   = 7'b000_0100,
    ST_COL   = 7'b000_1000,
    ST_DONE  = 7'b001_0000,
    ST_CBR   = 7'b010_0000,
    ST_PRE   = 7'b100_0000
  } fpd_state_e;
endpackage
`default_nettype wire

/* File: src/fpd_ctrl.sv */
`default_nettype none
module fpd_ctrl #(
  parameter int PAUSE_CYCLES = fpd_pkg::PAUSE_CYC,
  parameter int REF_CYCLES   = fpd_pkg::REF_INT_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          reqValid,
  input  wire fpd_pkg::fpd_req_s             reqData,
  input  wire logic                          refreshLapse,
  output var  logic                          reqReady,
  output var  logic                          rdValid,
  output var  logic [fpd_pkg::DATA_W-1:0]    rdData,
  output var  logic                          memReady,
  output var  fpd_pkg::fpd_pins_s            pins,
  output var  logic [fpd_pkg::DATA_W-1:0]    dqOut,
  output var  logic [1:0]                    dqOe,
  input  wire logic [fpd_pkg::DATA_W-1:0]    dqIn
);
  fpd_pkg::fpd_state_e stateReg;
  fpd_pkg::fpd_req_s   curReg;
  logic [17:0]         timerReg;
  logic [15:0]         refCntReg;
  logic                refDueReg;
  logic [3:0]          wakeReg;
  logic [fpd_pkg::DATA_W-1:0] dqSync1Reg;
  logic [fpd_pkg::DATA_W-1:0] dqSync2Reg;
  logic                lapseSync1Reg;
  logic                lapseSync2Reg;
  logic                timerDone;
  logic                takeReq;
  logic                colGo;

  //////////////////////////////////////////////////////////////////////
  // shared decodes
  assign timerDone = (timerReg == 18'h0_0000);
  // a raised ready is always honoured, ahead of refresh
  assign takeReq   = (stateReg == fpd_pkg::ST_IDLE) && reqValid && reqReady;
  // column phase starts once row hold has elapsed
  assign colGo     = timerDone && pins.lcasN && pins.ucasN;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqSync1Reg    <= 16'h0000;
      dqSync2Reg    <= 16'h0000;
      lapseSync1Reg <= 1'b0;
      lapseSync2Reg <= 1'b0;
    end else begin
      dqSync1Reg    <= dqIn;
      dqSync2Reg    <= dqSync1Reg;
      lapseSync1Reg <= refreshLapse;
      lapseSync2Reg <= lapseSync1Reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // refresh interval timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refCntReg <= 16'h0000;
      refDueReg <= 1'b0;
    end else if (stateReg == fpd_pkg::ST_CBR) begin
      refCntReg <= 16'h0000;
      refDueReg <= 1'b0;
    end else if (refCntReg >= 16'(REF_CYCLES)) begin
      refDueReg <= 1'b1;
    end else begin
      refCntReg <= refCntReg + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data capture, one-cycle valid pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData  <= 16'h0000;
    end else begin
      rdValid <= 1'b0;
      // wait covers access time and synchroniser
      if (stateReg == fpd_pkg::ST_DONE && timerDone && !curReg.write) begin
        rdValid <= 1'b1;
        rdData  <= dqSync2Reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // write data lanes, driven only inside a write cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dqOut <= 16'h0000;
      dqOe  <= 2'b00;
    end else if (takeReq) begin
      // data set up with the row, well before the strobe
      dqOut <= reqData.wdata;
    end else if (stateReg == fpd_pkg::ST_COL && colGo) begin
      dqOe  <= curReg.write ? curReg.byteEn : 2'b00;
    end else if (stateReg == fpd_pkg::ST_DONE && timerDone) begin
      // released with the strobes
      dqOe  <= 2'b00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // main sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg  <= fpd_pkg::ST_PAUSE;
      timerReg  <= 18'h0_0000;
      wakeReg   <= 4'h0;
      curReg    <= '0;
      reqReady  <= 1'b0;
      memReady  <= 1'b0;
      pins      <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 9'h000};
    end else begin
      if (!timerDone) begin
        timerReg <= timerReg - 18'h0_0001;
      end
      case (stateReg)
        fpd_pkg::ST_PAUSE: begin
          if (timerReg == 18'h0_0000 && wakeReg == 4'h0 && !memReady) begin
            timerReg <= 18'(PAUSE_CYCLES);
            wakeReg  <= 4'(fpd_pkg::WAKE_CNT);
            stateReg <= fpd_pkg::ST_PRE;
          end
        end
        fpd_pkg::ST_IDLE: begin
          if (takeReq) begin
            reqReady  <= 1'b0;
            curReg    <= reqData;
            pins.addr <= reqData.addr[17:9];
            pins.weN  <= ~reqData.write;
            pins.oeN  <= 1'b1;
            stateReg  <= fpd_pkg::ST_ROW;
          end else if (lapseSync2Reg) begin
            memReady <= 1'b0;
            reqReady <= 1'b0;
            wakeReg  <= 4'(fpd_pkg::WAKE_CNT);
            stateReg <= fpd_pkg::ST_PRE;
          end else if (refDueReg) begin
            reqReady   <= 1'b0;
            pins.lcasN <= 1'b0;
            pins.ucasN <= 1'b0;
            timerReg   <= 18'h0_0001;
            stateReg   <= fpd_pkg::ST_CBR;
          end else begin
            // ready low on return, so refresh and wake-up go first
            reqReady <= memReady;
          end
        end
        fpd_pkg::ST_ROW: begin
          pins.rasN <= 1'b0;
          timerReg  <= 18'h0_0001;
          stateReg  <= fpd_pkg::ST_COL;
        end
        fpd_pkg::ST_COL: begin
          if (colGo) begin
            // early write, data set before strobe
            pins.addr <= curReg.addr[8:0];
            pins.lcasN <= ~curReg.byteEn[0];
            pins.ucasN <= ~curReg.byteEn[1];
            pins.oeN <= curReg.write;
            timerReg <= 18'(fpd_pkg::TACC_CYC + 2);
            stateReg <= fpd_pkg::ST_DONE;
          end
        end
        fpd_pkg::ST_DONE: begin
          if (timerDone) begin
            pins      <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, pins.addr};
            timerReg  <= 18'(fpd_pkg::TRC_CYC);
            stateReg  <= fpd_pkg::ST_PRE;
          end
        end
        fpd_pkg::ST_CBR: begin
          if (timerDone && pins.rasN) begin
            pins.rasN <= 1'b0;
            timerReg  <= 18'(fpd_pkg::TRC_CYC);
          end else if (timerDone) begin
            pins     <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, pins.addr};
            timerReg <= 18'(fpd_pkg::TRC_CYC);
            stateReg <= fpd_pkg::ST_PRE;
          end
        end
        fpd_pkg::ST_PRE: begin
          if (timerDone) begin
            if (wakeReg != 4'h0) begin
              wakeReg    <= wakeReg - 4'h1;
              pins.lcasN <= 1'b0;
              pins.ucasN <= 1'b0;
              timerReg   <= 18'h0_0001;
              stateReg   <= fpd_pkg::ST_CBR;
            end else begin
              memReady <= 1'b1;
              stateReg <= fpd_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          stateReg <= fpd_pkg::ST_PAUSE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: testbench/fpd_dram_model.sv */
`default_nettype none
// behavioural memory behind the strobe pins
module fpd_dram_model (
  input  wire fpd_pkg::fpd_pins_s pins,
  input  wire logic [15:0]        dqOut,
  output var  logic [15:0]        dqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [2**18];
  logic [15:0] rd = '0;
  logic [8:0]  row = '0;
  int          refCnt = 0, k;
  // internal strobe spans both byte strobes
  wire logic casLo = !(pins.lcasN & pins.ucasN);
  // strobe before row strobe, a refresh
  always @(negedge pins.rasN) begin
    if (casLo) refCnt++;
    else row = pins.addr;
  end
  always @(posedge casLo) begin
    k = {row, pins.addr};
    if (!pins.rasN && !pins.weN) begin
      if (!pins.lcasN) mem[k][7:0] = dqOut[7:0];
      if (!pins.ucasN) mem[k][15:8] = dqOut[15:8];
    end else if (!pins.rasN) rd = mem[k];
  end
  // lane gives true data only under its strobe in a read with output enable low, inverted data otherwise
  always_comb begin
    dqIn[7:0] = pins.lcasN | pins.oeN | !pins.weN ? ~rd[7:0] : rd[7:0];
    dqIn[15:8] = pins.ucasN | pins.oeN | !pins.weN ? ~rd[15:8] : rd[15:8];
  end
endmodule
`default_nettype wire

/* File: testbench/fpd_ctrl_props.sv */
`default_nettype none
module fpd_ctrl_props (
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               reqReady,
  input wire logic               memReady,
  input wire fpd_pkg::fpd_pins_s pins,
  input wire logic [1:0]         dqOe
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic casLo = !(pins.lcasN & pins.ucasN);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // start of a row strobe cycle
  sequence s_row_start; $fell(pins.rasN); endsequence
  a_ready_gate: assert property (reqReady |-> memReady && pins.rasN)
    else $error("ready too early");
  a_we_stable: assert property (!pins.rasN && casLo &&
    $past(!pins.rasN && casLo) |-> $stable(pins.weN)) else $error("we moved");
  a_early_write: assert property ($rose(casLo) && !pins.rasN
    && !pins.weN |-> $past(!pins.weN)) else $error("late write");
  a_write_lanes: assert property (!pins.rasN && casLo && !pins.weN
    |-> pins.oeN && dqOe == ~{pins.ucasN, pins.lcasN}) else $error("lanes");
  a_read_quiet: assert property (pins.weN |-> dqOe == 2'b00)
    else $error("drive in read");
  a_ras_spacing: assert property (s_row_start |=> !$fell(pins.rasN) [*2])
    else $error("row cycle short");
  a_cas_width: assert property ($rose(casLo) |=> casLo)
    else $error("strobe short");
  a_cbr_order: assert property (s_row_start |-> !casLo || $past(casLo))
    else $error("refresh order");
endmodule
`default_nettype wire

/* File: testbench/tb_fpd_ctrl.sv */
`default_nettype none
module tb_fpd_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk = 0, rst_n = 0, reqValid = 0;
  logic               refreshLapse = 0, reqReady, rdValid, memReady;
  logic [15:0]        rdData, dqOut, dqIn;
  logic [1:0]         dqOe;
  fpd_pkg::fpd_req_s  reqData = '0;
  fpd_pkg::fpd_pins_s pins;
  int                 failures = 0, checksDone = 0, c;
  fpd_ctrl #(.PAUSE_CYCLES(10), .REF_CYCLES(50)) fpd_ctrl_i (.ref_clk,
    .rst_n, .reqValid, .reqData, .refreshLapse, .reqReady, .rdValid,
    .rdData, .memReady, .pins, .dqOut, .dqOe, .dqIn);
  fpd_dram_model fpd_dram_model_i (.pins, .dqOut, .dqIn);
  // free-running reference clock
  initial forever #20 ref_clk = ~ref_clk;
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checksDone++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // bounded wait for a flag level: 0 ready, 1 read valid, 2 memory ready
  task automatic waitFor(input int which, input logic v);
    int   n = 0;
    logic s;
    s = (which == 0) ? reqReady : (which == 1) ? rdValid : memReady;
    while (s !== v) begin
      @(posedge ref_clk);
      #1;
      s = (which == 0) ? reqReady : (which == 1) ? rdValid : memReady;
      if (++n > 600) begin
        check(0, "timeout");
        conclude;
      end
    end
  endtask
  // one request, reads compared under a mask
  task automatic req(input logic w, input logic [1:0] be,
      input logic [17:0] a, input logic [15:0] d, input logic [15:0] m);
    @(posedge ref_clk);
    #1;
    reqData = '{w, be, a, d};
    reqValid = 1;
    waitFor(0, 1);
    @(posedge ref_clk);
    #1;
    reqValid = 0;
    if (!w) waitFor(1, 1);
    if (!w) check((rdData & m) === (d & m), "read data");
  endtask
  task automatic tWake;
    waitFor(2, 1);
    check(fpd_dram_model_i.refCnt >= 8, "wake-up count");
    c = fpd_dram_model_i.refCnt;
    repeat (120) @(posedge ref_clk);
    #1;
    check(fpd_dram_model_i.refCnt - c >= 2, "refresh rate");
  endtask
  task automatic tBytes;
    req(1, 2'b11, 18'h0_0205, 16'hA5C3, 16'h0000);
    req(1, 2'b11, 18'h3_FE05, 16'h3C5A, 16'h0000);
    req(1, 2'b01, 18'h0_0205, 16'h0F1E, 16'h0000);
    req(0, 2'b11, 18'h0_0205, 16'hA51E, 16'hFFFF);
    req(0, 2'b10, 18'h0_0205, 16'hA51E, 16'hFF00);
    req(0, 2'b11, 18'h3_FE05, 16'h3C5A, 16'hFFFF);
  endtask
  task automatic tLapse;
    c = fpd_dram_model_i.refCnt;
    refreshLapse = 1;
    waitFor(2, 0);
    refreshLapse = 0;
    waitFor(2, 1);
    check(fpd_dram_model_i.refCnt - c >= 8, "wake-up repeat");
    req(0, 2'b11, 18'h3_FE05, 16'h3C5A, 16'hFFFF);
  endtask
  // mid-run reset: pins idle at once, then a full wake-up again
  task automatic tReset;
    @(posedge ref_clk);
    #1;
    c = fpd_dram_model_i.refCnt;
    rst_n = 0;
    #1;
    check(pins.rasN && pins.lcasN && !memReady && !reqReady, "reset");
    repeat (4) @(posedge ref_clk);
    #1;
    rst_n = 1;
    waitFor(2, 1);
    check(fpd_dram_model_i.refCnt - c >= 8, "wake after reset");
    req(0, 2'b11, 18'h3_FE05, 16'h3C5A, 16'hFFFF);
  endtask
  // reset, then scenarios
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    rst_n = 1;
    tWake;
    tBytes;
    tLapse;
    tReset;
    conclude;
  end
endmodule
bind fpd_ctrl fpd_ctrl_props fpd_ctrl_props_i (.ref_clk, .rst_n,
  .reqReady, .memReady, .pins, .dqOe);
`default_nettype wire
